/* shared/bsf_pkg.sv */
`default_nettype none

package bsf_pkg;

  // geometry
  localparam int          BSF_PC_W     = 13;              // program counter width
  localparam int          BSF_LATH_W   = 5;               // holding latch width, pc bits 12..8

  // bank-one byte addresses
  localparam logic [7:0]  BSF_A_INDW   = 8'h80;           // indirect_access_window
  localparam logic [7:0]  BSF_A_OPT    = 8'h81;           // timer_prescale_options
  localparam logic [7:0]  BSF_A_PCLO   = 8'h82;           // program_counter_low
  localparam logic [7:0]  BSF_A_STAT   = 8'h83;           // arith_status
  localparam logic [7:0]  BSF_A_PTR    = 8'h84;           // indirect_pointer
  localparam logic [7:0]  BSF_A_DIRA   = 8'h85;           // port_a_direction
  localparam logic [7:0]  BSF_A_DIRB   = 8'h86;           // port_b_direction
  localparam logic [7:0]  BSF_A_LATH   = 8'h8A;           // pc_high_latch
  localparam logic [7:0]  BSF_A_ICTL   = 8'h8B;           // interrupt_control
  localparam logic [7:0]  BSF_A_PIE    = 8'h8C;           // peripheral_irq_enable
  localparam logic [7:0]  BSF_A_RCAU   = 8'h8E;           // power_reset_cause
  localparam logic [7:0]  BSF_A_ANCF   = 8'h9F;           // analog_pin_config
  localparam logic [7:0]  BSF_A_LAST   = 8'h9F;           // top of the bank-one slice
  localparam logic [7:0]  BSF_BANK_BIT = 8'h80;           // bank-select bit of the address

  // reset values
  localparam logic [7:0]  BSF_RST_OPT  = 8'hFF;
  localparam logic [7:0]  BSF_RST_PCLO = 8'h00;
  localparam logic [7:0]  BSF_RST_STAT = 8'h18;           // upper three clear, timeout and powerdown set
  localparam logic [7:0]  BSF_RST_PTR  = 8'h00;           // unknown at power-up, zero chosen
  localparam logic [5:0]  BSF_RST_DIRA = 6'h3F;
  localparam logic [7:0]  BSF_RST_DIRB = 8'hFF;
  localparam logic [4:0]  BSF_RST_LATH = 5'h00;
  localparam logic [7:0]  BSF_RST_ICTL = 8'h00;
  localparam logic [1:0]  BSF_RST_ANCF = 2'h0;

  // status field positions
  localparam int          BSF_ST_IBS   = 7;               // indirect_bank_select
  localparam int          BSF_ST_UBS   = 6;               // upper_bank_select
  localparam int          BSF_ST_LBS   = 5;               // lower bank select
  localparam int          BSF_ST_TMO   = 4;               // timeout_flag
  localparam int          BSF_ST_PWD   = 3;               // powerdown_flag

  // power_reset_cause field positions
  localparam int          BSF_PC_MPEEN = 7;
  localparam int          BSF_PC_PER   = 2;
  localparam int          BSF_PC_POR   = 1;
  localparam int          BSF_PC_BOR   = 0;

  // interrupt_control: hardware-set flag bits
  localparam logic [7:0]  BSF_ICTL_FLG = 8'h07;
  localparam int          BSF_PIE_ADIE = 6;

  // register selected by the decoder
  typedef enum logic [3:0] {
    BSF_SEL_NONE, BSF_SEL_INDW, BSF_SEL_OPT, BSF_SEL_PCLO, BSF_SEL_STAT, BSF_SEL_PTR,
    BSF_SEL_DIRA, BSF_SEL_DIRB, BSF_SEL_LATH, BSF_SEL_ICTL, BSF_SEL_PIE, BSF_SEL_RCAU,
    BSF_SEL_ANCF
  } bsf_sel_t;

  // cause of the current reset, several may be set
  typedef struct packed {
    logic por;                                            // power-on
    logic bor;                                            // brown-out
    logic per;                                            // parity error
    logic ext;                                            // external_reset_pin
    logic wdt;                                            // watchdog timeout
  } bsf_cause_t;

  // data-memory access from the core
  typedef struct packed {
    logic       rd;                                       // read strobe
    logic       wr;                                       // write strobe
    logic [7:0] addr;                                     // bank bit plus offset
    logic [7:0] wdata;                                    // write data
  } bsf_bus_req_t;

  // access forwarded through the indirect window
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [8:0] addr;                                     // indirect_bank_select plus pointer
    logic [7:0] wdata;
  } bsf_ind_req_t;

endpackage : bsf_pkg

`default_nettype wire

/* tb/bsf_bank1_regs_assertions.sv */
`timescale 1ns/1ns
`default_nettype none

// port-level checker for the bank-one register slice
module bsf_bank1_regs_assertions
  import bsf_pkg::*;
#(
  parameter int PC_W = BSF_PC_W                   // program counter width
)(
  input wire logic             i_sys_clk,         // core clock
  input wire logic             i_reset,           // sync reset
  input wire logic             i_clk_en,          // state advance enable
  input wire bsf_bus_req_t     i_bus,             // core access
  input wire logic [7:0]       i_ind_rd_data,     // data behind the window
  input wire logic [2:0]       i_irq_set,         // event inputs
  input wire logic [7:0]       o_rd_data,         // read data
  input wire logic             o_hit,             // slice claims address
  input wire bsf_ind_req_t     o_ind,             // indirect access
  input wire logic             o_pc_load,         // counter load pulse
  input wire logic [PC_W-1:0]  o_pc_target,       // counter load value
  input wire logic [4:0]       o_pc_latch,        // upper counter latch
  input wire logic [1:0]       o_bank_select,     // direct bank bits
  input wire logic             o_indirect_bank,   // indirect bank bit
  input wire logic [7:0]       o_option,          // option register
  input wire logic [5:0]       o_port_a_dir,      // port a direction
  input wire logic [7:0]       o_port_b_dir,      // port b direction
  input wire logic [7:0]       o_int_control,     // interrupt control
  input wire logic             o_adc_irq_en,      // converter irq enable
  input wire logic [1:0]       o_analog_cfg       // analog pin config
);
  // a bus request is taken on this edge
  logic take;
  assign take = i_clk_en && !i_reset;

  AST_HIT_MAP:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      o_hit == (i_bus.addr inside {[8'h80:8'h9F], 8'h00, 8'h02, 8'h03, 8'h04, 8'h0A, 8'h0B}))
      else $error("hit flag disagrees with address");
  AST_PC_LOAD:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.wr && i_bus.addr == 8'h82
      |=> o_pc_load && o_pc_target == {$past(o_pc_latch), $past(i_bus.wdata)})
      else $error("counter load missing or wrong target");
  AST_LATCH_WR:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.wr && i_bus.addr inside {8'h0A, 8'h8A}
      |=> o_pc_latch == $past(i_bus.wdata[4:0]))
      else $error("latch write not seen from both banks");
  AST_BANK_WR:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.wr && i_bus.addr inside {8'h03, 8'h83}
      |=> {o_indirect_bank, o_bank_select} == $past(i_bus.wdata[7:5]))
      else $error("bank bits not written from both banks");
  AST_HOLE_RD:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.rd && i_bus.addr inside {[8'h87:8'h89], 8'h8D, [8'h8F:8'h9E]}
      |=> o_rd_data == 8'h00)
      else $error("hole did not read zero");
  AST_MISS_HOLD:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.rd && !o_hit |=> $stable(o_rd_data))
      else $error("read data changed on a miss");
  AST_IND_RD:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.rd && i_bus.addr inside {8'h00, 8'h80}
      |-> o_ind.rd && o_ind.addr[8] == o_indirect_bank ##1 o_rd_data == $past(i_ind_rd_data))
      else $error("indirect read not forwarded");
  AST_IND_WR:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.wr && i_bus.addr inside {8'h00, 8'h80}
      |-> o_ind.wr && !o_ind.rd && o_ind.wdata == i_bus.wdata
      && o_ind.addr[8] == o_indirect_bank)
      else $error("indirect write not forwarded");
  AST_IND_QUIET:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !(i_bus.addr inside {8'h00, 8'h80}) |-> !o_ind.rd && !o_ind.wr)
      else $error("indirect strobe outside the window");
  AST_ICTL_SET:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      take && i_bus.wr && i_bus.addr inside {8'h0B, 8'h8B}
      |=> o_int_control == ($past(i_bus.wdata) | {5'h00, $past(i_irq_set)}))
      else $error("interrupt control write or event set wrong");
  AST_RST_ALL:
    assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $fell(i_reset) && $past(i_clk_en) |-> o_option == 8'hFF && o_port_a_dir == 6'h3F
      && o_port_b_dir == 8'hFF && o_pc_latch == 5'h00 && !o_pc_load && !o_adc_irq_en
      && o_analog_cfg == 2'h0 && o_bank_select == 2'h0 && !o_indirect_bank)
      else $error("common reset values wrong");
endmodule : bsf_bank1_regs_assertions

bind bsf_bank1_regs bsf_bank1_regs_assertions #(.PC_W(PC_W)) u_bsf_chk (
  .i_sys_clk, .i_reset, .i_clk_en, .i_bus, .i_ind_rd_data, .i_irq_set, .o_rd_data, .o_hit,
  .o_ind, .o_pc_load, .o_pc_target, .o_pc_latch, .o_bank_select, .o_indirect_bank,
  .o_option, .o_port_a_dir, .o_port_b_dir, .o_int_control, .o_adc_irq_en, .o_analog_cfg);

`default_nettype wire

/* tb/bsf_bank1_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none

// self-checking bench for the bank-one register slice
module bsf_bank1_regs_tb
  import bsf_pkg::*;
;
  // power-class reset table
  localparam logic [7:0] RA [11] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8A,
                                     8'h8B, 8'h8C, 8'h8E, 8'h9F};
  localparam logic [7:0] RE [11] = '{8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'h00,
                                     8'h00, 8'h00, 8'h85, 8'h00};
  // later resets: pin, watchdog, brown-out
  localparam bsf_cause_t XC [3] = '{5'h02, 5'h01, 5'h08};
  localparam logic       XS [3] = '{1'b1, 1'b1, 1'b0};
  localparam logic [7:0] XA [6] = '{8'h81, 8'h83, 8'h84, 8'h8A, 8'h8B, 8'h8E};
  localparam logic [7:0] XE [3][6] = '{'{8'hFF, 8'h1D, 8'hA5, 8'h00, 8'h01, 8'h80},
                                       '{8'hFF, 8'h0D, 8'hA5, 8'h00, 8'h01, 8'h80},
                                       '{8'hFF, 8'h18, 8'h00, 8'h00, 8'h00, 8'h06}};

  logic         clk, rst, clk_en, strap, pc_upd, clrwdt, sleep, pc_load;  // scalar pins
  bsf_cause_t   cause;                            // reset cause
  bsf_bus_req_t bus;                              // core access
  logic [7:0]   ind_data, rd_data;                // window data, read data
  logic [12:0]  pc_val, pc_tgt;                   // counter in and out
  logic [2:0]   irq;                              // event inputs
  int           failures, checked;                // counts

  bsf_bank1_regs #(.PC_W(13)) DUT (
    .i_sys_clk(clk), .i_reset(rst), .i_clk_en(clk_en), .i_cause(cause),
    .i_parity_strap(strap), .i_bus(bus), .o_rd_data(rd_data), .o_hit(), .o_ind(),
    .i_ind_rd_data(ind_data), .i_pc_update(pc_upd), .i_pc_value(pc_val),
    .i_clrwdt(clrwdt), .i_sleep(sleep), .i_irq_set(irq), .o_pc_load(pc_load),
    .o_pc_target(pc_tgt), .o_pc_latch(), .o_bank_select(), .o_indirect_bank(),
    .o_option(), .o_port_a_dir(), .o_port_b_dir(), .o_int_control(),
    .o_adc_irq_en(), .o_analog_cfg());

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // compare and report
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one access, held up to the taking edge
  task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d);
  endtask : wr

  // read, data lands one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b1, 1'b0, a, 8'h00);
    #1;
    chk(rd_data, e);
  endtask : rd

  // one-edge reset with a chosen cause
  task automatic do_reset(input bsf_cause_t c, input logic s);
    @(posedge clk);
    rst <= 1'b1;
    cause <= c;
    strap <= s;
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // hang guard
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  // main sequence
  initial begin
    int i, k;
    failures = 0;
    checked = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    cause = 5'h10;
    strap = 1'b1;
    bus = '0;
    ind_data = 8'hC3;
    pc_upd = 1'b0;
    pc_val = '0;
    clrwdt = 1'b0;
    sleep = 1'b0;
    irq = 3'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 11; i++) rd(RA[i], RE[i]);
    for (i = 8'h87; i <= 8'h9E; i++) begin
      if (!(i inside {8'h8A, 8'h8B, 8'h8C, 8'h8E})) begin
        wr(i[7:0], 8'hFF);
        rd(i[7:0], 8'h00);
      end
    end
    wr(8'h8A, 8'hFF);
    rd(8'h8A, 8'h1F);
    wr(8'h9F, 8'hFF);
    rd(8'h9F, 8'h03);
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'h40);
    wr(8'h04, 8'h5A);
    rd(8'h84, 8'h5A);
    wr(8'h8B, 8'h80);
    rd(8'h0B, 8'h80);
    wr(8'h0A, 8'h03);
    rd(8'h8A, 8'h03);
    rd(8'h00, 8'hC3);
    rd(8'h80, 8'hC3);
    rd(8'h01, 8'hC3);
    wr(8'h8A, 8'h13);
    wr(8'h82, 8'h10);
    #1;
    chk(pc_load, 1'b1);
    chk(pc_tgt, 13'h1310);
    @(posedge clk);
    #1;
    chk(pc_load, 1'b0);
    @(posedge clk);
    pc_upd <= 1'b1;
    pc_val <= 13'h0ABC;
    @(posedge clk);
    pc_upd <= 1'b0;
    rd(8'h82, 8'hBC);
    wr(8'h03, 8'h25);
    rd(8'h83, 8'h3D);
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    rd(8'h83, 8'h35);
    @(posedge clk);
    clrwdt <= 1'b1;
    @(posedge clk);
    clrwdt <= 1'b0;
    rd(8'h83, 8'h3D);
    @(posedge clk);
    irq <= 3'h3;
    @(posedge clk);
    irq <= 3'h0;
    rd(8'h8B, 8'h83);
    // frozen clock enable ignores writes
    @(posedge clk);
    clk_en <= 1'b0;
    wr(8'h81, 8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(8'h81, 8'hFF);
    wr(8'h84, 8'hA5);
    wr(8'h81, 8'h00);
    wr(8'h8E, 8'h00);
    rd(8'h8E, 8'h80);
    for (k = 0; k < 3; k++) begin
      do_reset(XC[k], XS[k]);
      for (i = 0; i < 6; i++) rd(XA[i], XE[k][i]);
    end
    wr(8'h00, 8'h77);
    @(posedge clk);
    irq <= 3'h4;
    wr(8'h8B, 8'h00);
    irq <= 3'h0;
    rd(8'h0B, 8'h04);
    final_report();
  end
endmodule : bsf_bank1_regs_tb

`default_nettype wire

/* verilog/bsf_addr_decode.sv */
`timescale 1ns/1ns
`default_nettype none

// maps a banked address onto one register of the slice
module bsf_addr_decode
  import bsf_pkg::*;
(
  input  wire logic [7:0] i_addr,                         // core data address
  output var bsf_sel_t    o_sel,                          // selected register
  output logic            o_hit                           // address belongs to this slice
);

  logic [7:0] bank1_addr;                                 // address forced into bank one
  logic       mirrored;                                   // location shared by both banks

  // bank-zero aliases of the shared locations
  always_comb begin
    bank1_addr = i_addr | BSF_BANK_BIT;
    mirrored = (bank1_addr == BSF_A_INDW) || (bank1_addr == BSF_A_PCLO) ||
               (bank1_addr == BSF_A_STAT) || (bank1_addr == BSF_A_PTR)  ||
               (bank1_addr == BSF_A_LATH) || (bank1_addr == BSF_A_ICTL);
    o_hit = i_addr[7] ? (i_addr <= BSF_A_LAST) : mirrored;
  end

  // offset to register; holes give none
  always_comb begin
    o_sel = BSF_SEL_NONE;
    if (o_hit) begin
      case (bank1_addr)
        BSF_A_INDW: o_sel = BSF_SEL_INDW;
        BSF_A_OPT:  o_sel = BSF_SEL_OPT;
        BSF_A_PCLO: o_sel = BSF_SEL_PCLO;
        BSF_A_STAT: o_sel = BSF_SEL_STAT;
        BSF_A_PTR:  o_sel = BSF_SEL_PTR;
        BSF_A_DIRA: o_sel = BSF_SEL_DIRA;
        BSF_A_DIRB: o_sel = BSF_SEL_DIRB;
        BSF_A_LATH: o_sel = BSF_SEL_LATH;
        BSF_A_ICTL: o_sel = BSF_SEL_ICTL;
        BSF_A_PIE:  o_sel = BSF_SEL_PIE;
        BSF_A_RCAU: o_sel = BSF_SEL_RCAU;
        BSF_A_ANCF: o_sel = BSF_SEL_ANCF;
        default:    o_sel = BSF_SEL_NONE;
      endcase
    end
  end

endmodule : bsf_addr_decode

`default_nettype wire

/* verilog/bsf_bank1_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - shared registers reachable from both banks
// - only low program counter byte mapped
// - five-bit latch feeds upper pc, reset zero
// - power-up resets and other resets differ
// - pin and watchdog resets are other class
// - holes read zero, writes ignored
// - unchanged bits survive non-power-up resets
// - timeout and powerdown follow reset cause
module bsf_bank1_regs
  import bsf_pkg::*;
#(
  parameter int PC_W = BSF_PC_W                           // program counter width
)(
  input  wire logic                  i_sys_clk,           // core clock
  input  wire logic                  i_reset,             // sync reset, active high
  input  wire logic                  i_clk_en,            // freezes all state when low
  input  wire bsf_cause_t            i_cause,             // cause of the reset in progress
  input  wire logic                  i_parity_strap,      // parity checking enable strap
  input  wire bsf_bus_req_t          i_bus,               // core access
  output logic [7:0]                 o_rd_data,           // read data, one cycle later
  output logic                       o_hit,               // address claimed by this slice
  output var bsf_ind_req_t           o_ind,               // indirect window access
  input  wire logic [7:0]            i_ind_rd_data,       // data behind the indirect window
  input  wire logic                  i_pc_update,         // core advanced the counter
  input  wire logic [PC_W-1:0]       i_pc_value,          // counter value from the core
  input  wire logic                  i_clrwdt,            // watchdog clear executed
  input  wire logic                  i_sleep,             // sleep executed
  input  wire logic [2:0]            i_irq_set,           // timer, edge, port-change events
  output logic                       o_pc_load,           // software wrote the low byte
  output logic [PC_W-1:0]            o_pc_target,         // counter value to load
  output logic [BSF_LATH_W-1:0]      o_pc_latch,          // latch for branch targets
  output logic [1:0]                 o_bank_select,       // direct bank select
  output logic                       o_indirect_bank,     // indirect bank select
  output logic [7:0]                 o_option,            // timer and prescaler options
  output logic [5:0]                 o_port_a_dir,        // port a direction, 1 input
  output logic [7:0]                 o_port_b_dir,        // port b direction, 1 input
  output logic [7:0]                 o_int_control,       // interrupt enables and flags
  output logic                       o_adc_irq_en,        // converter interrupt enable
  output logic [1:0]                 o_analog_cfg         // analog pin configuration
);

  // refuse widths the latch cannot serve
  if (PC_W != BSF_LATH_W + 8) begin : g_bad_width
    $error("bsf_bank1_regs: PC_W must be eight plus the latch width");
  end

  // whole state of the slice
  typedef struct packed {
    logic [7:0]            option;                        // timer_prescale_options
    logic [7:0]            pc_low;                        // program_counter_low
    logic [7:0]            status;                        // arith_status
    logic [7:0]            ptr;                           // indirect_pointer
    logic [5:0]            dira;                          // port_a_direction
    logic [7:0]            dirb;                          // port_b_direction
    logic [BSF_LATH_W-1:0] lath;                          // pc_high_latch
    logic [7:0]            ictl;                          // interrupt_control
    logic                  adie;                          // peripheral_irq_enable bit
    logic                  mpeen;                         // parity enable, read only
    logic                  per_ok;                        // low after parity reset
    logic                  por_ok;                        // low after power-on reset
    logic                  bor_ok;                        // low after brown-out reset
    logic [1:0]            ancf;                          // analog_pin_config
    logic [7:0]            rd_data;                       // registered read data
    logic                  pc_load;                       // load pulse
    logic [PC_W-1:0]       pc_target;                     // load value
  } bsf_state_t;

  bsf_state_t state_reg;                                  // registered state
  bsf_state_t state_next;                                 // next state
  bsf_sel_t   sel;                                        // decoded register
  logic       hit;                                        // decoder hit
  logic       wr_en;                                      // qualified write
  logic       rd_en;                                      // qualified read
  logic       power_class;                                // power-up reset class
  logic [7:0] rd_mux;                                     // read value before the flop

  // address decoder
  // both banks alike for the shared locations
  bsf_addr_decode u_decode (
    .i_addr (i_bus.addr),
    .o_sel  (sel),
    .o_hit  (hit)
  );

  assign wr_en = i_bus.wr && hit;
  assign rd_en = i_bus.rd && hit;
  assign o_hit = hit;

  assign power_class = i_cause.por || i_cause.bor || i_cause.per;

  // indirect window forwarding, handshake outputs
  always_comb begin
    o_ind.rd    = rd_en && (sel == BSF_SEL_INDW);
    o_ind.wr    = wr_en && (sel == BSF_SEL_INDW);
    o_ind.addr  = {state_reg.status[BSF_ST_IBS], state_reg.ptr};
    o_ind.wdata = i_bus.wdata;
  end

  // read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    case (sel)
      BSF_SEL_INDW: rd_mux = i_ind_rd_data;
      BSF_SEL_OPT:  rd_mux = state_reg.option;
      BSF_SEL_PCLO: rd_mux = state_reg.pc_low;
      BSF_SEL_STAT: rd_mux = state_reg.status;
      BSF_SEL_PTR:  rd_mux = state_reg.ptr;
      BSF_SEL_DIRA: rd_mux = {2'h0, state_reg.dira};
      BSF_SEL_DIRB: rd_mux = state_reg.dirb;
      BSF_SEL_LATH: rd_mux = {3'h0, state_reg.lath};
      BSF_SEL_ICTL: rd_mux = state_reg.ictl;
      BSF_SEL_PIE:  rd_mux = {1'h0, state_reg.adie, 6'h00};
      BSF_SEL_RCAU: rd_mux = {state_reg.mpeen, 4'h0, state_reg.per_ok,
                              state_reg.por_ok, state_reg.bor_ok};
      BSF_SEL_ANCF: rd_mux = {6'h00, state_reg.ancf};
      default:      rd_mux = 8'h00;
    endcase
  end

  // next-state logic
  always_comb begin
    state_next         = state_reg;
    state_next.pc_load = 1'b0;
    if (i_reset) begin
      state_next.option = BSF_RST_OPT;
      state_next.dira   = BSF_RST_DIRA;
      state_next.dirb   = BSF_RST_DIRB;
      state_next.pc_low = BSF_RST_PCLO;
      state_next.lath   = BSF_RST_LATH;
      state_next.ancf   = BSF_RST_ANCF;
      state_next.adie   = 1'b0;
      state_next.rd_data   = 8'h00;
      state_next.pc_target = '0;
      state_next.status[7:5] = BSF_RST_STAT[7:5];
      state_next.mpeen       = i_parity_strap;
      state_next.ictl[7:1]   = BSF_RST_ICTL[7:1];
      if (power_class) begin
        state_next.status = BSF_RST_STAT;
        state_next.ptr    = BSF_RST_PTR;
        state_next.ictl   = BSF_RST_ICTL;
        // cause flags: cleared for the cause seen
        state_next.por_ok = !i_cause.por;
        state_next.bor_ok = !i_cause.bor;
        state_next.per_ok = !i_cause.per;
      end else begin
        // unchanged bits kept as they are
        if (i_cause.wdt) begin
          state_next.status[BSF_ST_TMO] = 1'b0;
        end
      end
    end else begin
      // counter tracking from the core
      if (i_pc_update) begin
        state_next.pc_low = i_pc_value[7:0];
      end
      if (i_clrwdt) begin
        state_next.status[BSF_ST_TMO] = 1'b1;
        state_next.status[BSF_ST_PWD] = 1'b1;
      end else if (i_sleep) begin
        state_next.status[BSF_ST_TMO] = 1'b1;
        state_next.status[BSF_ST_PWD] = 1'b0;
      end
      // register writes
      if (wr_en) begin
        case (sel)
          BSF_SEL_OPT:  state_next.option = i_bus.wdata;
          BSF_SEL_PCLO: begin
            state_next.pc_low    = i_bus.wdata;
            state_next.pc_load   = 1'b1;
            state_next.pc_target = {state_reg.lath, i_bus.wdata};
          end
          BSF_SEL_STAT: begin
            // upper bank bits stored as written
            state_next.status[7:5] = i_bus.wdata[7:5];
            state_next.status[2:0] = i_bus.wdata[2:0];
          end
          BSF_SEL_PTR:  state_next.ptr  = i_bus.wdata;
          BSF_SEL_DIRA: state_next.dira = i_bus.wdata[5:0];
          BSF_SEL_DIRB: state_next.dirb = i_bus.wdata;
          BSF_SEL_LATH: state_next.lath = i_bus.wdata[BSF_LATH_W-1:0];
          BSF_SEL_ICTL: state_next.ictl = i_bus.wdata;
          BSF_SEL_PIE:  state_next.adie = i_bus.wdata[BSF_PIE_ADIE];
          BSF_SEL_RCAU: begin
            // cause flags rearmed by software
            state_next.per_ok = i_bus.wdata[BSF_PC_PER];
            state_next.por_ok = i_bus.wdata[BSF_PC_POR];
            state_next.bor_ok = i_bus.wdata[BSF_PC_BOR];
          end
          BSF_SEL_ANCF: state_next.ancf = i_bus.wdata[1:0];
          default:      state_next.ancf = state_reg.ancf;
        endcase
      end
      // event flags: set wins over a clearing write
      state_next.ictl = state_next.ictl | ({5'h00, i_irq_set} & BSF_ICTL_FLG);
      // read data captured
      if (rd_en) begin
        state_next.rd_data = rd_mux;
      end
    end
  end

  // state register, frozen by the clock enable
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // outputs from the state
  assign o_rd_data       = state_reg.rd_data;
  assign o_pc_load       = state_reg.pc_load;
  assign o_pc_target     = state_reg.pc_target;
  assign o_pc_latch      = state_reg.lath;
  assign o_bank_select   = state_reg.status[BSF_ST_UBS:BSF_ST_LBS];
  assign o_indirect_bank = state_reg.status[BSF_ST_IBS];
  assign o_option        = state_reg.option;
  assign o_port_a_dir    = state_reg.dira;
  assign o_port_b_dir    = state_reg.dirb;
  assign o_int_control   = state_reg.ictl;
  assign o_adc_irq_en    = state_reg.adie;
  assign o_analog_cfg    = state_reg.ancf;

endmodule : bsf_bank1_regs

`default_nettype wire
